// ===== hdl/csc_channel.sv
`timescale 1ns/10ps
module csc_channel #(
  parameter int unsigned SCK_HALF = csc_pkg::SCK_HALF_CYC
)(
  input  wire logic              clock,      // System clock, 100 MHz.
  input  wire logic              rst,        // Synchronous reset, active high.
  input  wire logic [7:0]        addr,       // Register address.
  input  wire logic [7:0]        wdata,      // Write data.
  input  wire logic              wr,         // Write strobe.
  input  wire logic              rd,         // Read strobe.
  output logic      [7:0]        rdata,      // Read data, valid the cycle after rd.
  output logic                   irq,        // Transfer interrupt, level.
  input  wire logic              si,         // Serial data in pin.
  input  wire logic              parity_err, // Parity error event from same clock.
  output csc_pkg::csc_pins_t     pins        // Serial clock and data-out pins.
);

  csc_pkg::csc_state_t state;
  csc_pkg::csc_chan_t  chan;
  logic                chan_enable;
  logic                chan_busy;
  logic                chan_parity;
  logic                chan_overrun;
  logic [7:0]          port_dir;
  logic [7:0]          mask;
  logic [7:0]          ist;
  logic [7:0]          rx_byte;
  logic                rx_full;
  logic [7:0]          shreg;
  logic [2:0]          bit_cnt;
  logic [15:0]         div_cnt;
  logic                sck_lvl;
  logic                so_lvl;
  logic                done;
  logic                si_meta;
  logic                si_sync;

  function automatic logic wr_bit(input logic [7:0] a, input logic [7:0] d,
                                  input logic [7:0] ra, input int unsigned b);
    wr_bit = (a == ra) && d[b];
  endfunction

  logic start_wr;
  logic stop_wr;
  logic launch;
  logic pe_clr;
  logic ov_clr;
  logic data_rd;
  logic ist_rd;

  assign start_wr = wr && wr_bit(addr, wdata, csc_pkg::ADDR_START, csc_pkg::BIT_START);
  assign stop_wr  = wr && wr_bit(addr, wdata, csc_pkg::ADDR_STOP, csc_pkg::BIT_STOP);
  assign pe_clr   = wr && wr_bit(addr, wdata, csc_pkg::ADDR_ERR_CLEAR, csc_pkg::BIT_PARITY_CLEAR);
  assign ov_clr   = wr && wr_bit(addr, wdata, csc_pkg::ADDR_ERR_CLEAR, csc_pkg::BIT_OVERRUN_CLEAR);
  assign launch   = wr && (addr == csc_pkg::ADDR_DATA) && chan.enable && (state == csc_pkg::CSC_IDLE);
  assign data_rd  = rd && (addr == csc_pkg::ADDR_DATA);
  assign ist_rd   = rd && (addr == csc_pkg::ADDR_IRQ_STAT);
  assign chan     = '{enable: chan_enable, busy: chan_busy, parity: chan_parity, overrun: chan_overrun};

  // The data pin comes from another domain, so it passes two flops first.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      si_meta <= 1'b0;
      si_sync <= 1'b0;
    end
    else
    begin
      si_meta <= si;
      si_sync <= si_meta;
    end
  end

  // Channel enable: start sets it, stop clears it.
  always_ff @(posedge clock)
  begin
    if (rst)
      chan_enable <= 1'b0;
    else if (start_wr)
      chan_enable <= 1'b1;
    else if (stop_wr)
      chan_enable <= 1'b0;
  end

  // Shift engine. Clock idles high, data leaves on the falling edge and
  // is sampled on the rising edge, most significant bit first.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state   <= csc_pkg::CSC_IDLE;
      shreg   <= csc_pkg::DATA_RESET;
      bit_cnt <= 3'h0;
      div_cnt <= 16'h0000;
      sck_lvl <= 1'b1;
      so_lvl  <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (stop_wr)
      begin
        // A stop mid-byte abandons the byte and returns the clock to idle.
        state   <= csc_pkg::CSC_IDLE;
        sck_lvl <= 1'b1;
      end
      else
      begin
        unique case (state)
          csc_pkg::CSC_IDLE:
          begin
            if (launch)
            begin
              state   <= csc_pkg::CSC_SHIFT;
              shreg   <= wdata;
              so_lvl  <= wdata[7];
              bit_cnt <= 3'h0;
              div_cnt <= 16'h0000;
            end
          end
          csc_pkg::CSC_SHIFT:
          begin
            if (div_cnt == 16'(SCK_HALF - 1))
            begin
              div_cnt <= 16'h0000;
              so_lvl  <= sck_lvl ? shreg[7] : so_lvl;
              if (sck_lvl)
                sck_lvl <= 1'b0;
              else
              begin
                sck_lvl <= 1'b1;
                shreg   <= {shreg[6:0], si_sync};
                if (bit_cnt == csc_pkg::LAST_BIT)
                begin
                  state <= csc_pkg::CSC_IDLE;
                  done  <= 1'b1;
                end
                else
                  bit_cnt <= bit_cnt + 3'h1;
              end
            end
            else
              div_cnt <= div_cnt + 16'h0001;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      chan_busy <= 1'b0;
    else
      chan_busy <= (state == csc_pkg::CSC_SHIFT) && !stop_wr && !done;
  end

  // Received byte and its unread marker; a new byte wins over a read.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rx_byte <= csc_pkg::DATA_RESET;
      rx_full <= 1'b0;
    end
    else
    begin
      if (done)
        rx_byte <= shreg;
      if (done)
        rx_full <= 1'b1;
      else if (data_rd)
        rx_full <= 1'b0;
    end
  end

  // Error flags. A new error in the clearing cycle is kept.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      chan_overrun <= 1'b0;
      chan_parity  <= 1'b0;
    end
    else
    begin
      if (done && rx_full && !data_rd)
        chan_overrun <= 1'b1;
      else if (ov_clr)
        chan_overrun <= 1'b0;
      if (parity_err)
        chan_parity <= 1'b1;
      else if (pe_clr)
        chan_parity <= 1'b0;
    end
  end

  // Direction, mask and sticky interrupt status.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      port_dir <= csc_pkg::DIR_RESET;
      mask     <= csc_pkg::MASK_RESET;
      ist      <= 8'h00;
    end
    else
    begin
      if (wr && addr == csc_pkg::ADDR_PORT_DIR)
        port_dir <= wdata | csc_pkg::DIR_FIXED_ONES;
      if (wr && addr == csc_pkg::ADDR_IRQ_MASK)
        mask <= wdata;
      if (done)
        ist[csc_pkg::BIT_XFER_IRQ] <= 1'b1;
      else if (ist_rd)
        ist[csc_pkg::BIT_XFER_IRQ] <= 1'b0;
    end
  end

  // The interrupt follows status one cycle later, which keeps it a flop output.
  always_ff @(posedge clock)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(ist & ~mask);
  end

  // Pins. Software must clear both direction bits for master use.
  always_ff @(posedge clock)
  begin
    if (rst)
      pins <= '{sck_o: 1'b1, sck_oe: 1'b0, so_o: 1'b0, so_oe: 1'b0};
    else
    begin
      pins.sck_o  <= sck_lvl;
      pins.so_o   <= so_lvl;
      pins.sck_oe <= !port_dir[csc_pkg::BIT_DIR_SCK];
      pins.so_oe  <= !port_dir[csc_pkg::BIT_DIR_SO];
    end
  end

  // Read data stand for exactly one cycle; unmapped and write-only read zero.
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (!rd)
      rdata <= 8'h00;
    else
    begin
      unique case (addr)
        csc_pkg::ADDR_PORT_DIR:  rdata <= port_dir;
        csc_pkg::ADDR_IRQ_MASK:  rdata <= mask;
        csc_pkg::ADDR_DATA:      rdata <= rx_byte;
        csc_pkg::ADDR_IRQ_STAT:  rdata <= ist;
        csc_pkg::ADDR_CHAN_STAT:
        begin
          rdata <= 8'h00;
          rdata[csc_pkg::BIT_STAT_ENABLE]  <= chan.enable;
          rdata[csc_pkg::BIT_STAT_BUSY]    <= chan.busy;
          rdata[csc_pkg::BIT_STAT_PARITY]  <= chan.parity;
          rdata[csc_pkg::BIT_STAT_OVERRUN] <= chan.overrun;
        end
        default:                 rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_launch;
    launch;
  endsequence

  sequence s_finish;
    done;
  endsequence

  property p_pe_clear;
    pe_clr && !parity_err |=> !chan.parity;
  endproperty
  a_pe_clear: assert property (p_pe_clear) else $error("parity flag not cleared");

  property p_pe_keep;
    wr && addr == csc_pkg::ADDR_ERR_CLEAR && !wdata[csc_pkg::BIT_PARITY_CLEAR] && chan.parity |=> chan.parity;
  endproperty
  a_pe_keep: assert property (p_pe_keep) else $error("parity flag lost on zero write");

  property p_ov_clear;
    ov_clr && !done |=> !chan.overrun;
  endproperty
  a_ov_clear: assert property (p_ov_clear) else $error("overrun flag not cleared");

  property p_ov_keep;
    wr && addr == csc_pkg::ADDR_ERR_CLEAR && !wdata[csc_pkg::BIT_OVERRUN_CLEAR] && chan.overrun |=> chan.overrun;
  endproperty
  a_ov_keep: assert property (p_ov_keep) else $error("overrun flag lost on zero write");

  property p_dir_oe;
    ##1 (pins.so_oe == !$past(port_dir[csc_pkg::BIT_DIR_SO]))
      && (pins.sck_oe == !$past(port_dir[csc_pkg::BIT_DIR_SCK]));
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("pin enable disagrees with direction");

  property p_start;
    start_wr |=> chan.enable;
  endproperty
  a_start: assert property (p_start) else $error("start did not enable channel");

  property p_stop;
    stop_wr && !start_wr |=> !chan.enable && state == csc_pkg::CSC_IDLE && !done;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt channel");

  property p_irq_mask;
    irq |-> $past(ist[csc_pkg::BIT_XFER_IRQ] && !mask[csc_pkg::BIT_XFER_IRQ]);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt passed a mask");

  property p_xfer_done;
    s_launch |-> ##[1:1000] (done || !chan.enable);
  endproperty
  a_xfer_done: assert property (p_xfer_done) else $error("transfer never completed");

  property p_done_irq;
    s_finish ##1 !mask[csc_pkg::BIT_XFER_IRQ] |=> irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("completion raised no interrupt");

  property p_rx_read;
    data_rd && !done |=> rdata == $past(rx_byte);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("received byte not returned");

endmodule

// ===== hdl/csc_pkg.sv
// Summary of operation
// - Writing 1 to the parity clear bit zeroes the parity error flag; 0 leaves it.
// - Writing 1 to the overrun clear bit zeroes the overrun flag; 0 leaves it.
// - A direction bit at 0 drives its pin as output; at 1 the pin floats.
// - Writing 1 to the start bit sets channel enable and allows communication.
// - Transfer interrupt mask at 0 lets the interrupt through; at 1 blocks it.
// - The data byte takes the transmit byte on write while enabled and idle, gives received byte on read.
// - Writing 1 to the stop bit clears channel enable and halts communication.
package csc_pkg;

  // Link timing: system clock period and serial clock period.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCK_PERIOD_NS = 80;
  localparam int unsigned SCK_HALF_RAW  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned SCK_HALF_CYC  = (SCK_HALF_RAW < 1) ? 1 : SCK_HALF_RAW;

  // Register addresses.
  localparam logic [7:0] ADDR_ERR_CLEAR  = 8'h00;
  localparam logic [7:0] ADDR_PORT_DIR   = 8'h01;
  localparam logic [7:0] ADDR_START      = 8'h02;
  localparam logic [7:0] ADDR_STOP       = 8'h03;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h04;
  localparam logic [7:0] ADDR_DATA       = 8'h05;
  localparam logic [7:0] ADDR_CHAN_STAT  = 8'h06;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h07;

  // Field positions.
  localparam int unsigned BIT_PARITY_CLEAR  = 1;
  localparam int unsigned BIT_OVERRUN_CLEAR = 0;
  localparam int unsigned BIT_DIR_SCK       = 2;
  localparam int unsigned BIT_DIR_SO        = 0;
  localparam int unsigned BIT_START         = 0;
  localparam int unsigned BIT_STOP          = 0;
  localparam int unsigned BIT_XFER_IRQ      = 3;
  localparam int unsigned BIT_STAT_OVERRUN  = 0;
  localparam int unsigned BIT_STAT_PARITY   = 1;
  localparam int unsigned BIT_STAT_BUSY     = 6;
  localparam int unsigned BIT_STAT_ENABLE   = 7;

  // Reset values and fixed read bits.
  localparam logic [7:0] DIR_RESET      = 8'hff;
  localparam logic [7:0] DIR_FIXED_ONES = 8'he0;
  localparam logic [7:0] MASK_RESET     = 8'hff;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam logic [2:0] LAST_BIT       = 3'h7;

  typedef enum logic {CSC_IDLE, CSC_SHIFT} csc_state_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic so_o;
    logic so_oe;
  } csc_pins_t;

  typedef struct packed {
    logic enable;
    logic busy;
    logic parity;
    logic overrun;
  } csc_chan_t;

endpackage

// ===== test/csc_eeprom_model.sv
`timescale 1ns/10ps
module csc_eeprom_model (
  input  wire logic       clock,  // System clock.
  input  wire logic       sck,    // Serial clock pin.
  input  wire logic       so,     // Data from the master.
  output logic            si,     // Data to the master.
  output logic      [7:0] rx_byte // Last byte taken in.
);
  logic [7:0] tx_byte = 8'h00;
  logic [3:0] cnt     = 4'h8;
  logic       so_mid  = 1'b0;
  initial si = 1'b0;
  initial rx_byte = 8'h00;
  task automatic load(input logic [7:0] b);
    tx_byte = b;
    cnt = 4'h0;
  endtask
  // Mid-cycle copy, so a data change at the clock edge cannot race the sample.
  always @(negedge clock) so_mid <= so;
  always @(negedge sck)
  begin
    if (cnt < 4'h8)
      si = tx_byte[3'h7 - cnt[2:0]];
  end
  always @(posedge sck)
  begin
    if (cnt < 4'h8)
    begin
      rx_byte = {rx_byte[6:0], so_mid};
      cnt = cnt + 4'h1;
      // Once released the line shows the inverse, never the last bit.
      if (cnt == 4'h8)
        si = ~si;
    end
  end
endmodule

// ===== test/tb_clocked_serial_channel_control.sv
`timescale 1ns/10ps
module tb_clocked_serial_channel_control;
  localparam logic [7:0] A_ST = csc_pkg::ADDR_CHAN_STAT;
  localparam logic [7:0] A_DT = csc_pkg::ADDR_DATA;
  localparam logic [7:0] A_IS = csc_pkg::ADDR_IRQ_STAT;
  localparam logic [7:0] A_EC = csc_pkg::ADDR_ERR_CLEAR;
  logic               clock      = 1'b0;
  logic               rst        = 1'b1;
  logic [7:0]         addr       = 8'h00;
  logic [7:0]         wdata      = 8'h00;
  logic               wr         = 1'b0;
  logic               rd         = 1'b0;
  logic               parity_err = 1'b0;
  logic [7:0]         rdata;
  logic               irq;
  logic               si;
  logic [7:0]         slave_rx;
  csc_pkg::csc_pins_t pins;
  int                 num_errors  = 0;
  int                 check_count = 0;
  logic [7:0]         v;
  logic [7:0]         b;
  logic [7:0]         tx;
  logic [7:0]         back;
  always #5 clock = ~clock;
  csc_channel #(.SCK_HALF(4)) i_csc_channel (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .si(si), .parity_err(parity_err), .pins(pins));
  csc_eeprom_model i_csc_eeprom_model (.clock(clock), .sck(pins.sck_o), .so(pins.so_o), .si(si),
    .rx_byte(slave_rx));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 back = rdata;
    chk(back, exp, what);
  endtask
  function automatic logic [7:0] stat(input int en, input int busy, input int par, input int ovr);
    stat = 8'h00;
    stat[csc_pkg::BIT_STAT_ENABLE] = (en != 0);
    stat[csc_pkg::BIT_STAT_BUSY] = (busy != 0);
    stat[csc_pkg::BIT_STAT_PARITY] = (par != 0);
    stat[csc_pkg::BIT_STAT_OVERRUN] = (ovr != 0);
  endfunction
  // Polls the busy bit; a transfer of 64 cycles needs far fewer than 100 reads.
  task automatic byte_xfer(input logic [7:0] d);
    int n;
    wr_reg(A_DT, d);
    for (n = 0; n < 100; n++)
    begin
      @(posedge clock);
      rd <= 1'b1;
      addr <= A_ST;
      @(posedge clock);
      rd <= 1'b0;
      #1 back = rdata;
      if (back[csc_pkg::BIT_STAT_BUSY] === 1'b0)
        break;
    end
    if (n == 100)
    begin
      num_errors++;
      $display("Error at %0t: transfer never ended", $time);
      give_verdict();
    end
    repeat (3) @(posedge clock);
    #1;
  endtask
  initial
  begin
    void'($urandom(32'h095e06be));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 chk({6'h00, pins.sck_oe, pins.so_oe}, 8'h00, "oe at reset");
    rd_chk(csc_pkg::ADDR_PORT_DIR, csc_pkg::DIR_RESET, "dir reset");
    rd_chk(csc_pkg::ADDR_IRQ_MASK, csc_pkg::MASK_RESET, "mask reset");
    rd_chk(A_EC, 8'h00, "clear reg read");
    rd_chk(8'h3c, 8'h00, "unmapped read");
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($urandom);
      v[2] = k[1];
      v[0] = k[0];
      wr_reg(csc_pkg::ADDR_PORT_DIR, v);
      rd_chk(csc_pkg::ADDR_PORT_DIR, v | csc_pkg::DIR_FIXED_ONES, "dir");
      chk({6'h00, pins.sck_oe, pins.so_oe}, {6'h00, ~v[2], ~v[0]}, "oe");
    end
    wr_reg(csc_pkg::ADDR_PORT_DIR, 8'h00);
    wr_reg(A_DT, 8'ha5);
    rd_chk(A_ST, stat(0, 0, 0, 0), "write while off");
    wr_reg(csc_pkg::ADDR_START, 8'hfe);
    rd_chk(A_ST, stat(0, 0, 0, 0), "start with 0");
    wr_reg(csc_pkg::ADDR_START, 8'h01);
    rd_chk(A_ST, stat(1, 0, 0, 0), "start");
    for (int k = 0; k < 4; k++)
    begin
      v = k[0] ? 8'hf7 : 8'hff;
      wr_reg(csc_pkg::ADDR_IRQ_MASK, v);
      b = (k == 0) ? 8'h81 : 8'($urandom);
      tx = (k == 1) ? 8'h7e : 8'($urandom);
      i_csc_eeprom_model.load(b);
      byte_xfer(tx);
      chk({7'h00, irq}, {7'h00, ~v[3]}, "irq level");
      chk(slave_rx, tx, "byte sent");
      rd_chk(A_DT, b, "byte received");
      rd_chk(A_IS, 8'h08, "done status");
      rd_chk(A_IS, 8'h00, "status cleared");
      chk({7'h00, irq}, 8'h00, "irq after clear");
    end
    i_csc_eeprom_model.load(8'h3c);
    byte_xfer(8'hc3);
    i_csc_eeprom_model.load(8'h5a);
    byte_xfer(8'h5a);
    @(posedge clock);
    parity_err <= 1'b1;
    @(posedge clock);
    parity_err <= 1'b0;
    rd_chk(A_ST, stat(1, 0, 1, 1), "both flags");
    wr_reg(A_EC, 8'h00);
    rd_chk(A_ST, stat(1, 0, 1, 1), "clear with 0");
    wr_reg(A_EC, 8'h02);
    rd_chk(A_ST, stat(1, 0, 0, 1), "parity clear");
    wr_reg(A_EC, 8'h01);
    rd_chk(A_ST, stat(1, 0, 0, 0), "overrun clear");
    rd_chk(A_IS, 8'h08, "done status");
    i_csc_eeprom_model.load(8'h00);
    wr_reg(A_DT, 8'h99);
    repeat (20) @(posedge clock);
    wr_reg(csc_pkg::ADDR_STOP, 8'h00);
    rd_chk(A_ST, stat(1, 1, 0, 0), "stop with 0");
    @(posedge clock);
    #1 chk(rdata, 8'h00, "read data gone");
    wr_reg(csc_pkg::ADDR_STOP, 8'h01);
    rd_chk(A_ST, stat(0, 0, 0, 0), "stop");
    repeat (80) @(posedge clock);
    rd_chk(A_IS, 8'h00, "no done after stop");
    chk({7'h00, irq}, 8'h00, "no irq after stop");
    give_verdict();
  end
endmodule
